// ==== rtl/cbb_balance_ctrl.sv ====
// Bleed decision logic for passive balancing of a series cell stack.
// Assumes the cell monitor presents scan results with a one-cycle scan_done
// pulse and presents cell voltages one at a time via cell_sel / cell_mv.
`timescale 1ns/1ns
`default_nettype none
module cbb_balance_ctrl
  import cbb_pkg::*;
#(
  parameter int unsigned NCELL = CELL_COUNT,
  parameter int unsigned AW    = $clog2(NCELL),
  parameter longint      QUIET_MIN_CYC = MIN_QUIET_CYC
) (
  input  wire logic                     sys_clk,
  input  wire logic                     nrst,
  input  wire logic                     clk_en,
  // Configuration
  input  wire logic [MV_W-1:0]          floor_mv,
  input  wire logic [MV_W-1:0]          margin_mv,
  input  wire logic signed [TEMP_W-1:0] temp_ceiling,
  input  wire logic signed [CUR_W-1:0]  cur_low_ma,
  input  wire logic signed [CUR_W-1:0]  cur_high_ma,
  input  wire logic [31:0]              scan_period_cyc,
  input  wire logic [31:0]              quiet_cyc,
  input  wire logic                     voltage_mode_set,
  input  wire logic                     imbalance_mode_set,
  // Scan results
  input  wire logic                     scan_done,
  input  wire logic [MV_W-1:0]          cell_mv,
  input  wire logic [MV_W-1:0]          min_cell_mv,
  input  wire logic signed [TEMP_W-1:0] max_temp,
  input  wire logic signed [CUR_W-1:0]  stack_ma,
  input  wire logic [6:0]               soc_pct,
  // Estimator input and persistence
  input  wire logic                     est_valid,
  input  wire logic                     est_confident,
  input  wire logic [AW-1:0]            est_cell,
  input  wire logic [EST_W-1:0]         est_value,
  input  wire logic                     restore_valid,
  input  wire logic [AW-1:0]            restore_cell,
  input  wire logic [EST_W-1:0]         restore_value,
  input  wire logic [EST_W-1:0]         bleed_step,
  // Outputs
  output logic [AW-1:0]                 cell_sel,
  output logic [NCELL-1:0]              bleed_en,
  output logic                          quiet_phase,
  output logic                          voltage_mode,
  output logic                          imbalance_mode,
  output logic                          balance_done,
  output logic                          save_valid,
  output logic [AW-1:0]                 save_cell,
  output logic [EST_W-1:0]              save_value
);
  // ==========================================================================
  // Mode selection
  logic next_voltage_mode;
  logic next_imbalance_mode;

  always_comb begin
    next_voltage_mode   = voltage_mode;
    next_imbalance_mode = imbalance_mode;
    if (voltage_mode_set) begin
      next_voltage_mode   = 1'b1;
      next_imbalance_mode = 1'b0;
    end else if (imbalance_mode_set) begin
      next_voltage_mode   = 1'b0;
      next_imbalance_mode = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      voltage_mode   <= 1'b0;
      imbalance_mode <= 1'b0;
    end else if (clk_en) begin
      voltage_mode   <= next_voltage_mode;
      imbalance_mode <= next_imbalance_mode;
    end
  end

  // ==========================================================================
  // Scan period timer: bleed, then quiet before the next scan
  cbb_phase_t  phase;
  cbb_phase_t  next_phase;
  logic [31:0] tmr;
  logic [31:0] next_tmr;
  logic [31:0] quiet_eff;

  assign quiet_eff = (quiet_cyc < 32'(QUIET_MIN_CYC)) ? 32'(QUIET_MIN_CYC) : quiet_cyc;

  always_comb begin
    next_phase = phase;
    next_tmr   = tmr + 32'h1;
    if (scan_done) begin
      next_phase = PH_BLEED;
      next_tmr   = 32'h0;
    end else begin
      unique case (phase)
        PH_IDLE:  next_tmr = 32'h0;
        PH_BLEED: begin
          if (tmr + quiet_eff >= scan_period_cyc) begin
            next_phase = PH_QUIET;
          end
        end
        PH_QUIET: next_tmr = tmr;
        default:  next_phase = PH_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      phase <= PH_IDLE;
      tmr   <= 32'h0;
    end else if (clk_en) begin
      phase <= next_phase;
      tmr   <= next_tmr;
    end
  end

  assign quiet_phase = (phase != PH_BLEED);

  // ==========================================================================
  // Walk over all cells after each scan
  cbb_walk_t        walk;
  cbb_walk_t        next_walk;
  logic [AW-1:0]    next_cell_sel;
  logic [AW-1:0]    wcell;
  logic [AW-1:0]    next_wcell;
  logic [NCELL-1:0] dec;
  logic [NCELL-1:0] next_dec;
  logic             any_left;
  logic             next_any_left;
  logic             gate_ok;
  logic             next_gate_ok;
  logic [EST_W-1:0] est_rd;
  logic [EST_W-1:0] est_dec;
  logic             volt_ok;
  logic             cell_want;
  logic             mem_we;
  logic [AW-1:0]    mem_wa;
  logic [EST_W-1:0] mem_wd;
  logic             est_window;

  assign est_window = (soc_pct > SOC_FULL_PCT) || (soc_pct < SOC_EMPTY_PCT);
  assign volt_ok    = (cell_mv >= floor_mv)
                   && (cell_mv >= min_cell_mv)
                   && ((cell_mv - min_cell_mv) >= margin_mv);
  assign est_dec    = (est_rd > bleed_step) ? est_rd - bleed_step : '0;
  assign cell_want  = voltage_mode ? volt_ok
                    : (imbalance_mode && (est_rd != '0) && (cell_mv >= floor_mv));

  always_comb begin
    next_walk     = walk;
    next_cell_sel = cell_sel;
    next_wcell    = wcell;
    next_dec      = dec;
    next_any_left = any_left;
    next_gate_ok  = gate_ok;
    mem_we        = 1'b0;
    mem_wa        = wcell;
    mem_wd        = est_dec;
    unique case (walk)
      WK_IDLE: begin
        if (scan_done) begin
          next_walk     = WK_READ;
          next_cell_sel = '0;
          next_any_left = 1'b0;
          next_gate_ok  = (max_temp <= temp_ceiling)
                       && (stack_ma >= cur_low_ma)
                       && (stack_ma <= cur_high_ma);
        end
      end
      WK_READ: begin
        next_walk  = WK_WRITE;
        next_wcell = cell_sel;
      end
      WK_WRITE: begin
        next_dec[wcell] = cell_want;
        if (imbalance_mode && cell_want && gate_ok) begin
          mem_we = 1'b1;
        end
        if (est_rd != '0) begin
          next_any_left = 1'b1;
        end
        if (cell_sel == AW'(NCELL - 1)) begin
          next_walk = WK_IDLE;
        end else begin
          next_walk     = WK_READ;
          next_cell_sel = cell_sel + AW'(1);
        end
      end
      default: next_walk = WK_IDLE;
    endcase
    if (!mem_we && restore_valid) begin
      mem_we = 1'b1;
      mem_wa = restore_cell;
      mem_wd = restore_value;
    end else if (!mem_we && est_valid && est_confident && est_window) begin
      mem_we = 1'b1;
      mem_wa = est_cell;
      mem_wd = est_value;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      walk     <= WK_IDLE;
      cell_sel <= '0;
      wcell    <= '0;
      dec      <= '0;
      any_left <= 1'b0;
      gate_ok  <= 1'b0;
    end else if (clk_en) begin
      walk     <= next_walk;
      cell_sel <= next_cell_sel;
      wcell    <= next_wcell;
      dec      <= next_dec;
      any_left <= next_any_left;
      gate_ok  <= next_gate_ok;
    end
  end

  // Estimate storage, one entry per cell
  cbb_est_mem #(.DEPTH(NCELL), .WIDTH(EST_W), .AW(AW)) u_mem (
    .sys_clk (sys_clk),
    .clk_en  (clk_en),
    .wr_en   (mem_we),
    .wr_addr (mem_wa),
    .wr_data (mem_wd),
    .rd_addr (cell_sel),
    .rd_data (est_rd)
  );

  // ==========================================================================
  // Bleed outputs and persistence copy
  logic [NCELL-1:0] next_bleed;

  always_comb begin
    next_bleed = '0;
    if (phase == PH_BLEED && gate_ok && walk == WK_IDLE
        && (voltage_mode || (imbalance_mode && any_left))) begin
      next_bleed = dec;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      bleed_en     <= '0;
      balance_done <= 1'b0;
      save_valid   <= 1'b0;
      save_cell    <= '0;
      save_value   <= '0;
    end else if (clk_en) begin
      bleed_en     <= next_bleed;
      balance_done <= imbalance_mode && !any_left && walk == WK_IDLE;
      save_valid   <= (walk == WK_WRITE);
      save_cell    <= wcell;
      save_value   <= mem_we && mem_wa == wcell ? mem_wd : est_rd;
    end
  end

  // ==========================================================================
  // Checks
  a_floor_guard: assert property (@(posedge sys_clk) disable iff (!nrst)
    (clk_en && walk == WK_WRITE && !(cell_mv >= floor_mv)) |=> !dec[wcell])
    else $error("bleed decided below floor");
  a_quiet_off: assert property (@(posedge sys_clk) disable iff (!nrst)
    (clk_en && phase != PH_BLEED) |=> (bleed_en == '0))
    else $error("bleed during quiet interval");
  a_gate_off: assert property (@(posedge sys_clk) disable iff (!nrst)
    (clk_en && !gate_ok) |=> (bleed_en == '0))
    else $error("bleed with gate closed");
  a_mode_excl: assert property (@(posedge sys_clk) disable iff (!nrst)
    !(voltage_mode && imbalance_mode))
    else $error("both modes enabled");
  a_mode_swap: assert property (@(posedge sys_clk) disable iff (!nrst)
    (clk_en && imbalance_mode_set && !voltage_mode_set) |=> (imbalance_mode && !voltage_mode))
    else $error("mode switch failed");
  a_scan_start: assert property (@(posedge sys_clk) disable iff (!nrst)
    (clk_en && scan_done && walk == WK_IDLE) |=> (walk == WK_READ && cell_sel == '0))
    else $error("walk not started on scan");
  a_temp_gate: assert property (@(posedge sys_clk) disable iff (!nrst)
    (clk_en && scan_done && walk == WK_IDLE && max_temp > temp_ceiling) |=> !gate_ok)
    else $error("hot stack not gated");
  a_cur_gate: assert property (@(posedge sys_clk) disable iff (!nrst)
    (clk_en && scan_done && walk == WK_IDLE
     && (stack_ma < cur_low_ma || stack_ma > cur_high_ma)) |=> !gate_ok)
    else $error("current window not gated");
  a_done_off: assert property (@(posedge sys_clk) disable iff (!nrst)
    (clk_en && !voltage_mode && !any_left) |=> (bleed_en == '0))
    else $error("bleed with no estimates left");
endmodule : cbb_balance_ctrl
`default_nettype wire

// ==== rtl/cbb_pkg.sv ====
// Constants and types for the cell bleed balance controller.
// Assumes one 250 MHz clock and scan results delivered by a cell monitor.
//
// Overview of operation
// - Never bleed a cell whose voltage is below the absolute floor.
// - Voltage mode bleeds a cell only if it exceeds the stack minimum by the margin.
// - Zero margin bleeds every cell down to the absolute floor.
// - Temperature above the ceiling disables bleeding on all cells.
// - Balancing allowed only while signed current is at or above the lower bound.
// - Balancing allowed only while signed current is at or below the upper bound.
// - All bleeding switches off once every scan cycle for unloaded measurement.
// - Bleeding stays off for the quiet interval before each measurement.
// - Only one algorithm runs; enabling one disables the other at once.
// - Continuous mode bleeds cells holding a nonzero imbalance estimate.
// - Estimates are taken only above 99% or below 10% charge.
// - Stored estimates update only with high confidence, else are kept.
// - Estimates are saved to persistent storage and restored after restart.
// - Provide 480 per-cell estimate entries.
// - Bleeding reduces estimates; balancing stops when all reach zero.
`default_nettype none
package cbb_pkg;
  // ==========================================================================
  // Sizes and thresholds
  localparam int unsigned CELL_COUNT      = 480;
  localparam int unsigned MV_W            = 16;
  localparam int unsigned EST_W           = 24;
  localparam int unsigned CUR_W           = 32;
  localparam int unsigned TEMP_W          = 16;
  localparam logic [6:0]  SOC_FULL_PCT    = 7'h63;
  localparam logic [6:0]  SOC_EMPTY_PCT   = 7'h0a;
  localparam longint      CLK_HZ          = 250000000;
  localparam int unsigned MIN_QUIET_MS    = 50;
  localparam longint      MIN_QUIET_CYC   = (MIN_QUIET_MS * CLK_HZ) / 1000;
  // ==========================================================================
  // Scan phase
  typedef enum logic [1:0] {
    PH_IDLE  = 2'b00,
    PH_BLEED = 2'b01,
    PH_QUIET = 2'b10
  } cbb_phase_t;
  // Walk over cells
  typedef enum logic [1:0] {
    WK_IDLE  = 2'b00,
    WK_READ  = 2'b01,
    WK_WRITE = 2'b10
  } cbb_walk_t;
endpackage : cbb_pkg
`default_nettype wire

// ==== rtl/cbb_est_mem.sv ====
// Per-cell imbalance estimate memory with a registered read port.
// Assumes single clock; write and read may share a cycle.
`timescale 1ns/1ns
`default_nettype none
module cbb_est_mem
  import cbb_pkg::*;
#(
  parameter int unsigned DEPTH = CELL_COUNT,
  parameter int unsigned WIDTH = EST_W,
  parameter int unsigned AW    = $clog2(DEPTH)
) (
  input  wire logic             sys_clk,
  input  wire logic             clk_en,
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic [AW-1:0]    rd_addr,
  output logic      [WIDTH-1:0] rd_data
);
  // ==========================================================================
  // Storage
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge sys_clk) begin
    if (clk_en) begin
      if (wr_en) begin
        mem[wr_addr] <= wr_data;
      end
      rd_data <= mem[rd_addr];
    end
  end
endmodule : cbb_est_mem
`default_nettype wire

// ==== verification/cbb_cell_model.sv ====
// Cell stack model: per-cell voltages seen by the monitor and the stack minimum.
// Assumes the bench loads voltages only while no cell walk is running.
`timescale 1ns/1ns
`default_nettype none
module cbb_cell_model #(
  parameter int unsigned N  = 8,
  parameter int unsigned AW = 3
) (
  input  wire logic          sys_clk,
  input  wire logic          set_en,
  input  wire logic [AW-1:0] set_idx,
  input  wire logic [15:0]   set_mv,
  input  wire logic [AW-1:0] cell_sel,
  output logic      [15:0]   cell_mv,
  output logic      [15:0]   min_cell_mv
);
  // ==========================================================================
  // Voltage store, addressed readout and stack minimum
  logic [15:0] mv [N];
  always_ff @(posedge sys_clk) begin
    if (set_en) mv[set_idx] <= set_mv;
  end
  assign cell_mv = mv[cell_sel];
  always_comb begin
    min_cell_mv = mv[0];
    for (int i = 1; i < N; i++) begin
      if (mv[i] < min_cell_mv) min_cell_mv = mv[i];
    end
  end
endmodule : cbb_cell_model
`default_nettype wire

// ==== verification/cbb_balance_ctrl_tb.sv ====
// Self-checking bench for the bleed decision block on a shrunk 8-cell stack.
// Assumes a short quiet minimum and a scan period of 120 cycles.
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
  $display("BAD %0t got %0h want %0h", $time, (g), (e)); end end
module cbb_balance_ctrl_tb;
  import cbb_pkg::*;
  localparam int unsigned N  = 8;
  localparam int unsigned AW = 3;
  localparam int          P  = 120;
  localparam int          Q  = 30;
  // ==========================================================================
  // Signals
  logic                     sys_clk = 1'b0, nrst = 1'b0, clk_en = 1'b1;
  logic [MV_W-1:0]          floor_mv = 16'h044c, margin_mv = '0, cell_mv, min_cell_mv;
  logic signed [TEMP_W-1:0] temp_ceiling = 16'sh0037, max_temp = '0;
  logic signed [CUR_W-1:0]  cur_low_ma = -32'sd10000, cur_high_ma = 32'sd200, stack_ma = '0;
  logic                     vset = 1'b0, iset = 1'b0, scan_done = 1'b0, set_en = 1'b0;
  logic                     est_valid = 1'b0, est_confident = 1'b0, restore_valid = 1'b0;
  logic [6:0]               soc_pct = '0;
  logic [AW-1:0]            est_cell = '0, restore_cell = '0, set_idx = '0, cell_sel, save_cell;
  logic [EST_W-1:0]         est_value = '0, restore_value = '0, save_value;
  logic [EST_W-1:0]         step = 24'h000040;
  logic [MV_W-1:0]          set_mv = '0;
  logic [N-1:0]             bleed_en;
  logic                     quiet_phase, voltage_mode, imbalance_mode, balance_done, save_valid;
  logic [31:0]              seed = 32'h5369;
  logic [MV_W-1:0]          vm [N];
  logic [EST_W-1:0]         e [N];
  int                       n_fail = 0, n_compared = 0, n_save = 0;
  logic [N-1:0]             cur_want = '0;
  logic                     cur_im = 1'b0;

  cbb_balance_ctrl #(.NCELL(N), .AW(AW), .QUIET_MIN_CYC(10)) dut_u (
    .sys_clk, .nrst, .clk_en, .floor_mv, .margin_mv, .temp_ceiling, .cur_low_ma,
    .cur_high_ma, .scan_period_cyc(32'(P)), .quiet_cyc(32'(Q)),
    .voltage_mode_set(vset), .imbalance_mode_set(iset), .scan_done, .cell_mv,
    .min_cell_mv, .max_temp, .stack_ma, .soc_pct, .est_valid, .est_confident, .est_cell,
    .est_value, .restore_valid, .restore_cell, .restore_value, .bleed_step(step), .cell_sel,
    .bleed_en, .quiet_phase, .voltage_mode, .imbalance_mode, .balance_done, .save_valid,
    .save_cell, .save_value);
  cbb_cell_model #(.N(N), .AW(AW)) cells_u (.sys_clk, .set_en, .set_idx, .set_mv,
    .cell_sel, .cell_mv, .min_cell_mv);

  always #2 sys_clk = ~sys_clk;
  // ==========================================================================
  // Helpers
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  function automatic logic [N-1:0] expect_bleed(input logic im);
    logic [N-1:0]    r;
    logic [MV_W-1:0] mn;
    logic            gate;
    mn = vm[0];
    for (int i = 1; i < N; i++) if (vm[i] < mn) mn = vm[i];
    gate = (max_temp <= temp_ceiling) && (stack_ma >= cur_low_ma)
           && (stack_ma <= cur_high_ma);
    for (int i = 0; i < N; i++) begin
      r[i] = gate && (vm[i] >= floor_mv)
             && (im ? (e[i] != '0) : ((vm[i] - mn) >= margin_mv));
    end
    return r;
  endfunction : expect_bleed
  function automatic logic [EST_W-1:0] expect_save(input logic [AW-1:0] c);
    if (cur_im && cur_want[c]) return (e[c] > step) ? e[c] - step : '0;
    return e[c];
  endfunction : expect_save
  // Persistence stream: one entry per cell per scan, in cell order
  always @(posedge sys_clk) begin
    if (save_valid === 1'b1) begin
      `CHK(save_cell, AW'(n_save))
      `CHK(save_value, expect_save(save_cell))
      n_save++;
    end
  end
  task automatic tick(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask : tick
  task automatic load_cells();
    set_en = 1'b1;
    for (int i = 0; i < N; i++) begin
      set_idx = AW'(i);
      set_mv = vm[i];
      tick(1);
    end
    set_en = 1'b0;
  endtask : load_cells
  task automatic scan(input logic im);
    logic [N-1:0] want;
    want = expect_bleed(im);
    cur_want = want;
    cur_im = im;
    n_save = 0;
    scan_done = 1'b1;
    tick(1);
    scan_done = 1'b0;
    max_temp = 16'(rnd());
    stack_ma = 32'(rnd());
    tick(2 * N + 8);
    `CHK(bleed_en, want)
    tick(P - Q - 2 * N - 14);
    `CHK(bleed_en, want)
    tick(10);
    `CHK(bleed_en, {N{1'b0}})
    `CHK(quiet_phase, 1'b1)
    tick(Q - 5);
    `CHK(n_save, N)
    for (int i = 0; i < N; i++) begin
      e[i] = expect_save(AW'(i));
    end
  endtask : scan
  task automatic end_of_test();
    if (n_fail == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_of_test
  // ==========================================================================
  // Main sequence
  initial begin
    int k;
    logic [6:0] sc [6];
    sc = '{7'h64, 7'h09, 7'h64, 7'h32, 7'h63, 7'h0a};
    repeat (6) @(posedge sys_clk);
    #1;
    nrst = 1'b1;
    restore_valid = 1'b1;
    for (int i = 0; i < N; i++) begin
      e[i] = '0;
      restore_cell = AW'(i);
      tick(1);
    end
    restore_valid = 1'b0;
    iset = 1'b1;
    tick(1);
    iset = 1'b0;
    `CHK({voltage_mode, imbalance_mode}, 2'b01)
    vset = 1'b1;
    iset = 1'b1;
    tick(1);
    vset = 1'b0;
    iset = 1'b0;
    `CHK({voltage_mode, imbalance_mode}, 2'b10)
    clk_en = 1'b0;
    iset = 1'b1;
    tick(2);
    `CHK({voltage_mode, imbalance_mode}, 2'b10)
    iset = 1'b0;
    clk_en = 1'b1;
    for (int s = 0; s < 24; s++) begin
      for (int i = 0; i < N; i++) vm[i] = 16'(1000 + rnd() % 3000);
      load_cells();
      floor_mv = 16'(1100 + rnd() % 2500);
      margin_mv = (s % 4 == 0) ? '0 : 16'(rnd() % 600);
      max_temp = temp_ceiling + 16'(rnd() % 7) - 16'sd3;
      k = rnd() % 5;
      stack_ma = (k == 0) ? cur_low_ma - 1 : (k == 1) ? cur_low_ma :
                 (k == 2) ? cur_high_ma : (k == 3) ? cur_high_ma + 1 : 32'sd0;
      scan(1'b0);
    end
    for (int i = 0; i < N; i++) vm[i] = 16'h0bb8;
    load_cells();
    floor_mv = 16'h044c;
    iset = 1'b1;
    tick(1);
    iset = 1'b0;
    est_valid = 1'b1;
    for (int i = 0; i < 6; i++) begin
      est_cell = AW'(i);
      est_confident = (i != 2);
      soc_pct = sc[i];
      est_value = 3 * step;
      if (i < 2) e[i] = 3 * step;
      tick(1);
    end
    est_valid = 1'b0;
    restore_valid = 1'b1;
    restore_cell = 3'h6;
    restore_value = step;
    e[6] = step;
    tick(1);
    restore_valid = 1'b0;
    for (int s = 0; s < 4; s++) begin
      max_temp = '0;
      stack_ma = '0;
      scan(1'b1);
      `CHK(balance_done, (s == 3))
    end
    `CHK(balance_done, 1'b1)
    end_of_test();
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_fail++;
    end_of_test();
  end
endmodule : cbb_balance_ctrl_tb
`default_nettype wire
